// ### design/ods_consts.svh
`ifndef ODS_CONSTS_SVH
`define ODS_CONSTS_SVH

// ==========================================================
// Timing
`define ODS_CLK_PERIOD_NS  4
`define ODS_DEBOUNCE1_NS   25000
`define ODS_DEBOUNCE2_NS   750000
`define ODS_DEBOUNCE3_NS   3000000
`define ODS_STABLE_TICKS   2'h3
`define ODS_FIFO_DEPTH     8

// ==========================================================
// Frame layout
`define ODS_CRC_POLY       5'h15
`define ODS_CRC_INIT       5'h00
`define ODS_FRAME_W        16
`define ODS_DATA_MSB       15
`define ODS_DATA_LSB       8
`define ODS_UV1_RESET      1'b1
`define ODS_MON_IDLE       3'h5
`define ODS_SEL_NONE       2'h0
`define ODS_SEL_SHORT      2'h1
`define ODS_SEL_MID        2'h2

`endif

// ### design/ods_pkg.sv
package ods_pkg;

   typedef logic [7:0] ods_chan_t;
   typedef logic [1:0] ods_dbsel_t;

   typedef struct packed {
      logic              cs_s1;
      logic              cs_s2;
      logic              cs_d;
      logic              sck_s1;
      logic              sck_s2;
      logic              sck_d;
      logic              sin_s1;
      logic              sin_s2;
      logic              sin_bit;
      ods_chan_t         in_s1;
      ods_chan_t         in_s2;
      ods_chan_t         in_d;
      logic [2:0]        mon_s1;
      logic [2:0]        mon_s2;
      ods_dbsel_t        sel_s1;
      ods_dbsel_t        sel_s2;
      logic              len_s1;
      logic              len_s2;
      logic [19:0]       div;
      ods_chan_t         filt;
      logic [7:0][1:0]   cnt;
      ods_chan_t         latest;
      logic [15:0]       sr;
      logic              fault_n;
   } ods_state_t;

endpackage : ods_pkg

// ### design/ods_serializer.sv
`timescale 1ns/1ns
// Contract
// - Debounce code selects none, 25us, 0.75ms, 3ms.
// - Accept level after three stable filter ticks.
// - Filter tick period is debounce time over three.
// - Short-lived changes never reach the shift register unless the debounce code is none.
// - Chip select fall captures filtered inputs.
// - Each serial clock advances output one bit.
// - Long mode is sixteen bits with status.
// - Status holds two supply flags, temperature, CRC.
// - Primary supply flag low while supply low.
// - Temperature flag high while too hot.
// - CRC polynomial x5 plus x4 plus x2 plus 1.
// - Length select high gives eight-bit register.
// - Serial input never alters device state.
// - Serial input bits follow own data out.
// - Primary undervoltage asserts fault output low.
// - Secondary monitor only clears its own flag.
// - Order: inputs eight to one, CRC, flags.
// - First bit appears when chip select falls.
// - Later bits change on serial clock fall.
// - Serial output released while chip select high.
`include "ods_consts.svh"

// ==========================================================
// Word FIFO
module ods_fifo
#(
   parameter int W     = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic         CLK_I,
   input  wire logic         RESET_I,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             count;
   } ods_fifo_state_t;

   ods_fifo_state_t st_r;
   ods_fifo_state_t st_nxt;
   logic            push;
   logic            pop;

   assign in_ready_o  = (st_r.count != (AW+1)'(DEPTH));
   assign out_valid_o = (st_r.count != '0);
   assign out_data_o  = st_r.mem[st_r.rp];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb
   begin
      st_nxt = st_r;
      if (push)
      begin
         st_nxt.mem[st_r.wp] = in_data_i;
         st_nxt.wp           = st_r.wp + 1'b1;
      end
      if (pop)
      begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      if (push && !pop)
      begin
         st_nxt.count = st_r.count + 1'b1;
      end
      else if (pop && !push)
      begin
         st_nxt.count = st_r.count - 1'b1;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
endmodule : ods_fifo

// ==========================================================
// Input serializer
module ods_serializer
#(
   parameter int TICK1_CYC = `ODS_DEBOUNCE1_NS / (3 * `ODS_CLK_PERIOD_NS),
   parameter int TICK2_CYC = `ODS_DEBOUNCE2_NS / (3 * `ODS_CLK_PERIOD_NS),
   parameter int TICK3_CYC = `ODS_DEBOUNCE3_NS / (3 * `ODS_CLK_PERIOD_NS)
)
(
   input  wire logic             CLK_I,
   input  wire logic             RESET_I,
   input  wire ods_pkg::ods_chan_t FIELD_INPUTS_I,
   input  wire logic             DEBOUNCE_SEL_LO_I,
   input  wire logic             DEBOUNCE_SEL_HI_I,
   input  wire logic             LENGTH_SELECT_I,
   input  wire logic             PRIMARY_SUPPLY_OK_I,
   input  wire logic             SECONDARY_SUPPLY_OK_I,
   input  wire logic             OVERTEMP_I,
   input  wire logic             CS_N_I,
   input  wire logic             SCK_I,
   input  wire logic             SERIAL_IN_I,
   output logic                  SERIAL_OUT_O,
   output logic                  SERIAL_OUT_OE_O,
   output logic                  FAULT_N_O,
   output logic                  FIFO_IN_READY_O
);
   import ods_pkg::*;

   ods_state_t st_r;
   ods_state_t st_nxt;
   logic       fifo_in_valid;
   logic       fifo_in_ready;
   ods_chan_t  fifo_in_data;
   logic       fifo_out_valid;
   logic       fifo_out_ready;
   ods_chan_t  fifo_out_data;
   logic       tick;
   logic [19:0] tick_lim;

   // Five-bit CRC over the eight inputs and three flags, first bit first.
   function automatic logic [4:0] crc5(input logic [10:0] bits);
      logic [4:0] c;
      logic       fb;
      c = `ODS_CRC_INIT;
      for (int i = 10; i >= 0; i--)
      begin
         fb = c[4] ^ bits[i];
         c  = {c[3:0], 1'b0};
         if (fb)
         begin
            c = c ^ `ODS_CRC_POLY;
         end
      end
      return c;
   endfunction : crc5

   // Filter tick length in system cycles for a debounce code.
   function automatic logic [19:0] tick_len(input ods_dbsel_t sel);
      logic [19:0] n;
      unique case (sel)
         `ODS_SEL_NONE:  n = 20'h00001;
         `ODS_SEL_SHORT: n = 20'(TICK1_CYC);
         `ODS_SEL_MID:   n = 20'(TICK2_CYC);
         default:        n = 20'(TICK3_CYC);
      endcase
      return n;
   endfunction : tick_len

   // Edges of a synchronised pin, from its newest and previous samples.
   function automatic logic edge_up(input logic now_v, input logic prev_v);
      return now_v && !prev_v;
   endfunction : edge_up

   function automatic logic edge_down(input logic now_v, input logic prev_v);
      return !now_v && prev_v;
   endfunction : edge_down

   // ==========================================================
   // FIFO between the filter and the capture stage
   ods_fifo #(
      .W     (8),
      .DEPTH (`ODS_FIFO_DEPTH)
   ) u_fifo (
      .CLK_I       (CLK_I),
      .RESET_I     (RESET_I),
      .in_valid_i  (fifo_in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (fifo_in_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready),
      .out_data_o  (fifo_out_data)
   );

   assign tick_lim       = tick_len(st_r.sel_s2);
   // Compare at-or-above, so that a shorter code chosen mid-count cannot
   // leave the divider running past its limit for a whole wrap of the counter.
   assign tick           = (st_r.div >= tick_lim - 20'h00001);
   // The capture copy is frozen during a frame, so the FIFO fills then.
   assign fifo_out_ready = st_r.cs_s2;

   always_comb
   begin
      logic [7:0] commit;
      logic       sck_rise;
      logic       sck_fall;
      logic       cs_fall;
      logic [10:0] crc_bits;
      commit   = '0;
      st_nxt   = st_r;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      cs_fall  = 1'b0;
      crc_bits = '0;

      st_nxt.cs_s1  = CS_N_I;
      st_nxt.cs_s2  = st_r.cs_s1;
      st_nxt.cs_d   = st_r.cs_s2;
      st_nxt.sck_s1 = SCK_I;
      st_nxt.sck_s2 = st_r.sck_s1;
      st_nxt.sck_d  = st_r.sck_s2;
      st_nxt.sin_s1 = SERIAL_IN_I;
      st_nxt.sin_s2 = st_r.sin_s1;
      st_nxt.in_s1  = FIELD_INPUTS_I;
      st_nxt.in_s2  = st_r.in_s1;
      st_nxt.in_d   = st_r.in_s2;
      st_nxt.mon_s1 = {PRIMARY_SUPPLY_OK_I, OVERTEMP_I, SECONDARY_SUPPLY_OK_I};
      st_nxt.mon_s2 = st_r.mon_s1;
      st_nxt.sel_s1 = {DEBOUNCE_SEL_HI_I, DEBOUNCE_SEL_LO_I};
      st_nxt.sel_s2 = st_r.sel_s1;
      st_nxt.len_s1 = LENGTH_SELECT_I;
      st_nxt.len_s2 = st_r.len_s1;

      // ==========================================================
      // Debounce filter
      st_nxt.div = tick ? '0 : st_r.div + 20'h00001;
      for (int i = 0; i < 8; i++)
      begin
         if (st_r.in_s2[i] != st_r.in_d[i])
         begin
            st_nxt.cnt[i] = 2'h0;
         end
         else if (st_r.sel_s2 == `ODS_SEL_NONE)
         begin
            commit[i] = (st_r.in_s2[i] != st_r.filt[i]);
         end
         else if (st_r.in_s2[i] == st_r.filt[i])
         begin
            st_nxt.cnt[i] = 2'h0;
         end
         else if (st_r.cnt[i] == `ODS_STABLE_TICKS)
         begin
            commit[i] = 1'b1;
         end
         else if (tick)
         begin
            st_nxt.cnt[i] = st_r.cnt[i] + 2'h1;
         end
      end
      fifo_in_data  = (st_r.filt & ~commit) | (st_r.in_s2 & commit);
      fifo_in_valid = (commit != '0);
      if (fifo_in_valid && fifo_in_ready)
      begin
         st_nxt.filt = fifo_in_data;
         for (int i = 0; i < 8; i++)
         begin
            if (commit[i])
            begin
               st_nxt.cnt[i] = 2'h0;
            end
         end
      end
      if (fifo_out_valid && fifo_out_ready)
      begin
         st_nxt.latest = fifo_out_data;
      end

      // ==========================================================
      // Supply fault
      st_nxt.fault_n = st_r.mon_s2[2];

      // ==========================================================
      // Serial shifter
      sck_rise = edge_up(st_r.sck_s2, st_r.sck_d);
      sck_fall = edge_down(st_r.sck_s2, st_r.sck_d);
      cs_fall  = edge_down(st_r.cs_s2, st_r.cs_d);
      if (sck_rise)
      begin
         st_nxt.sin_bit = st_r.sin_s2;
      end
      if (cs_fall)
      begin
         crc_bits        = {st_r.latest, st_r.mon_s2};
         st_nxt.sr[15:8] = st_r.latest;
         st_nxt.sr[7:3]  = crc5(crc_bits);
         st_nxt.sr[2:0]  = st_r.mon_s2;
      end
      else if (!st_r.cs_s2 && sck_fall)
      begin
         if (st_r.len_s2)
         begin
            st_nxt.sr[15:8] = {st_r.sr[14:8], st_r.sin_bit};
         end
         else
         begin
            st_nxt.sr = {st_r.sr[14:0], st_r.sin_bit};
         end
      end
   end

   // ==========================================================
   // State register
   // Synchronisers reset to the idle level of their pins, so that no false
   // select edge and no false supply fault follows the release of reset.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         st_r         <= '0;
         st_r.cs_s1   <= 1'b1;
         st_r.cs_s2   <= 1'b1;
         st_r.cs_d    <= 1'b1;
         st_r.mon_s1  <= `ODS_MON_IDLE;
         st_r.mon_s2  <= `ODS_MON_IDLE;
         st_r.fault_n <= `ODS_UV1_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // The enable follows the delayed select, which turns over on the same edge
   // as the capture, so the pin never shows a stale bit of the last frame.
   assign SERIAL_OUT_O    = st_r.sr[`ODS_DATA_MSB];
   assign SERIAL_OUT_OE_O = !st_r.cs_d;
   assign FAULT_N_O       = st_r.fault_n;
   assign FIFO_IN_READY_O = fifo_in_ready;
endmodule : ods_serializer

// ### sim/ods_serializer_checker.sv
`timescale 1ns/1ns
// ==========================================================
// Port timing checks.
module ods_serializer_checker
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic PRIMARY_SUPPLY_OK_I,
   input wire logic CS_N_I,
   input wire logic SCK_I,
   input wire logic SERIAL_OUT_O,
   input wire logic SERIAL_OUT_OE_O,
   input wire logic FAULT_N_O,
   input wire logic FIFO_IN_READY_O
);
   logic [3:0] ev_age_r;
   logic [5:0] cs_hi_r;
   logic       sck_d_r;
   logic       cs_d_r;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   // Cycles since the last clock fall or select fall, and since deselect.
   always_ff @(posedge CLK_I)
   begin
      sck_d_r <= SCK_I;
      cs_d_r <= CS_N_I;
      if (RESET_I || (sck_d_r && !SCK_I) || (cs_d_r && !CS_N_I)) ev_age_r <= 4'h0;
      else if (ev_age_r != 4'hf) ev_age_r <= ev_age_r + 4'h1;
      if (RESET_I || !CS_N_I) cs_hi_r <= 6'h00;
      else if (cs_hi_r != 6'h3f) cs_hi_r <= cs_hi_r + 6'h01;
   end
   a_oe_idle: assert property (CS_N_I [*5] |-> !SERIAL_OUT_OE_O)
      else $error("output enabled while deselected");
   a_oe_active: assert property (!CS_N_I [*5] |-> SERIAL_OUT_OE_O)
      else $error("output not enabled while selected");
   a_oe_rise: assert property ($fell(CS_N_I) |-> ##[2:4] SERIAL_OUT_OE_O)
      else $error("output enable late after select");
   a_fault_set: assert property (!PRIMARY_SUPPLY_OK_I [*5] |-> !FAULT_N_O)
      else $error("fault not asserted");
   a_fault_clear: assert property (PRIMARY_SUPPLY_OK_I [*5] |-> FAULT_N_O)
      else $error("fault asserted with supply good");
   a_hold_high: assert property ((SCK_I && !CS_N_I) [*6] |-> $stable(SERIAL_OUT_O))
      else $error("data moved during clock high");
   a_change_cause: assert property (!CS_N_I && $changed(SERIAL_OUT_O) |-> ev_age_r <= 4'h6)
      else $error("data moved without clock fall");
   a_ready_idle: assert property (cs_hi_r >= 6'h28 |-> FIFO_IN_READY_O)
      else $error("buffer not drained while deselected");
   c_fault: cover property ($fell(FAULT_N_O));
   c_full: cover property ($fell(FIFO_IN_READY_O));
   c_frame: cover property ($rose(SERIAL_OUT_OE_O) ##[1:30] SCK_I);
endmodule : ods_serializer_checker

// ### sim/ods_spi_master.sv
`timescale 1ns/1ns
// ==========================================================
// Serial master; clock rests low outside frames.
module ods_spi_master
(
   input  wire logic clk_i,
   input  wire logic serial_out_i,
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      sin_o
);
   initial
   begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      sin_o = 1'b0;
   end
   task automatic sel(input logic v);
      @(negedge clk_i);
      cs_n_o = v;
   endtask : sel
   task automatic xfer(input int n, input logic [23:0] s, output logic [23:0] r);
      r = 24'h000000;
      @(negedge clk_i);
      cs_n_o = 1'b0;
      sin_o = s[n-1];
      repeat (10) @(negedge clk_i);
      for (int i = n - 1; i >= 0; i--)
      begin
         sck_o = 1'b1;
         r = {r[22:0], serial_out_i};
         repeat (10) @(negedge clk_i);
         sck_o = 1'b0;
         if (i > 0) sin_o = s[i-1];
         repeat (10) @(negedge clk_i);
      end
      cs_n_o = 1'b1;
      sin_o = ~sin_o;
      repeat (10) @(negedge clk_i);
   endtask : xfer
endmodule : ods_spi_master

// ### sim/tb_ods_serializer.sv
`timescale 1ns/1ns
// ==========================================================
// Frame-level tests.
module tb_ods_serializer;
   import ods_pkg::*;
   logic       clk, rst, db_lo, db_hi, len_sel, pri_ok, sec_ok, ot;
   logic       cs_n, sck, serial_in, serial_out, oe, fault_n, ready;
   ods_chan_t  field;
   wire logic  serial_out_w;
   int         miscompares = 0;
   int         check_count = 0;
   int         tk [4] = '{0, 4, 8, 16};
   assign serial_out_w = oe ? serial_out : 1'bz;
   ods_serializer #(.TICK1_CYC(4), .TICK2_CYC(8), .TICK3_CYC(16)) u_ods_serializer (
      .CLK_I(clk), .RESET_I(rst), .FIELD_INPUTS_I(field), .DEBOUNCE_SEL_LO_I(db_lo),
      .DEBOUNCE_SEL_HI_I(db_hi), .LENGTH_SELECT_I(len_sel), .PRIMARY_SUPPLY_OK_I(pri_ok),
      .SECONDARY_SUPPLY_OK_I(sec_ok), .OVERTEMP_I(ot), .CS_N_I(cs_n), .SCK_I(sck),
      .SERIAL_IN_I(serial_in), .SERIAL_OUT_O(serial_out), .SERIAL_OUT_OE_O(oe), .FAULT_N_O(fault_n),
      .FIFO_IN_READY_O(ready));
   ods_spi_master u_ods_spi_master (
      .clk_i(clk), .serial_out_i(serial_out_w), .cs_n_o(cs_n), .sck_o(sck), .sin_o(serial_in));
   always #2 clk = ~clk;
   function automatic logic [15:0] frm(input logic [7:0] d, input logic u1, t, u2);
      logic [10:0] w;
      logic [4:0]  c;
      w = {d, u1, t, u2};
      c = 5'h00;
      for (int i = 10; i >= 0; i--) c = {c[3:0], 1'b0} ^ ((w[i] ^ c[4]) ? 5'h15 : 5'h00);
      return {d, c, u1, t, u2};
   endfunction : frm
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rd(input int n, input logic [23:0] s, input logic [23:0] e);
      logic [23:0] r;
      u_ods_spi_master.xfer(n, s, r);
      chk("frame", e, r);
      chk("output enable", 24'h0, {23'h0, oe});
   endtask : rd
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   initial
   begin
      #200000;
      miscompares++;
      test_done();
   end
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      field = 8'h00;
      {db_hi, db_lo, len_sel, pri_ok, ot, sec_ok} = 6'h05;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      chk("reset state", 24'h3, {22'h0, fault_n, ready});
      repeat (2) @(negedge clk);
      chk("fault after reset", 24'h1, {23'h0, fault_n});
      for (int k = 0; k < 8; k++)
      begin
         {pri_ok, ot, sec_ok} = 3'(k) ^ 3'h5;
         field = 8'ha5 ^ (8'(k) * 8'h25);
         repeat (20) @(negedge clk);
         chk("fault", {23'h0, pri_ok}, {23'h0, fault_n});
         rd(16, 24'h0, {8'h00, frm(field, pri_ok, ot, sec_ok)});
      end
      {pri_ok, ot, sec_ok} = 3'h5;
      for (int c = 1; c < 4; c++)
      begin
         {db_hi, db_lo} = 2'(c);
         field = 8'h00;
         repeat (4 * tk[c] + 20) @(negedge clk);
         field = 8'hff;
         repeat (3 * tk[c] / 2) @(negedge clk);
         field = 8'h00;
         rd(16, 24'h0, {8'h00, frm(8'h00, 1'b1, 1'b0, 1'b1)});
         field = 8'h3c;
         repeat (3 * tk[c] + 8) @(negedge clk);
         rd(16, 24'h0, {8'h00, frm(8'h3c, 1'b1, 1'b0, 1'b1)});
      end
      {db_hi, db_lo, len_sel} = 3'h1;
      field = 8'hc6;
      repeat (20) @(negedge clk);
      rd(16, 24'h00c300, {8'h00, 8'hc6, 8'hc3});
      len_sel = 1'b0;
      repeat (20) @(negedge clk);
      rd(24, 24'h960000, {frm(8'hc6, 1'b1, 1'b0, 1'b1), 8'h96});
      rd(16, 24'h00ffff, {8'h00, frm(8'hc6, 1'b1, 1'b0, 1'b1)});
      rd(16, 24'h0, {8'h00, frm(8'hc6, 1'b1, 1'b0, 1'b1)});
      u_ods_spi_master.sel(1'b0);
      for (int i = 0; i < 16; i++)
      begin
         field = 8'(i);
         repeat (6) @(negedge clk);
      end
      chk("fifo ready", 24'h0, {23'h0, ready});
      u_ods_spi_master.sel(1'b1);
      repeat (60) @(negedge clk);
      chk("fifo ready", 24'h1, {23'h0, ready});
      rd(16, 24'h0, {8'h00, frm(8'h0f, 1'b1, 1'b0, 1'b1)});
      test_done();
   end
endmodule : tb_ods_serializer
bind ods_serializer ods_serializer_checker u_ods_serializer_checker (
   .CLK_I, .RESET_I, .PRIMARY_SUPPLY_OK_I, .CS_N_I, .SCK_I, .SERIAL_OUT_O,
   .SERIAL_OUT_OE_O, .FAULT_N_O, .FIFO_IN_READY_O);
